// >>> irqfb_core_model.sv
// Behavioural processor core that retires instructions and acknowledges requests
`timescale 1ns/10ps
// ********************************************
// Core model
// ********************************************
module irqfb_core_model (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       ie_en,
   input  wire logic       ack_en,
   input  wire logic [3:0] ack_dly,
   input  wire logic       int_req,
   input  wire logic [5:0] int_src,
   input  wire logic [1:0] int_level,
   output logic            core_ie,
   output logic            core_instr_done,
   output logic            core_ack,
   output logic      [5:0] last_src,
   output logic      [1:0] last_lvl,
   output logic      [7:0] ack_cnt
);
   logic [3:0] wait_ff;
   logic [1:0] ins_ff;
   // One main instruction retires every fourth cycle, only while enabled
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         core_ie         <= 1'b0;
         ins_ff          <= 2'h0;
         core_instr_done <= 1'b0;
      end else begin
         core_ie         <= ie_en;
         ins_ff          <= ins_ff + 2'h1;
         core_instr_done <= (ins_ff == 2'h3) && core_ie;
      end
   end
   // Ack after a chosen wait; never twice in a row, since int_req lags one cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         core_ack <= 1'b0;
         wait_ff  <= 4'h0;
         last_src <= 6'h00;
         last_lvl <= 2'h0;
         ack_cnt  <= 8'h00;
      end else begin
         core_ack <= 1'b0;
         if (ack_en && int_req && !core_ack) begin
            if (wait_ff == ack_dly) begin
               core_ack <= 1'b1;
               last_src <= int_src;
               last_lvl <= int_level;
               ack_cnt  <= ack_cnt + 8'h01;
               wait_ff  <= 4'h0;
            end else begin
               wait_ff <= wait_ff + 4'h1;
            end
         end
      end
   end
endmodule // irqfb_core_model

// >>> irqfb_flag_group.sv
// One 16-bit request flag group built from a low and a high byte
`timescale 1ns/10ps
`include "irqfb_map.svh"
module irqfb_flag_group (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [15:0] hw_set,
   input  wire logic [1:0]  byte_wr,
   input  wire logic [15:0] wr_data,
   input  wire logic [15:0] bit_wr,
   input  wire logic        bit_val,
   input  wire logic [15:0] ack_clr,
   output logic      [15:0] flags_ff
);
   logic [15:0] sw_mask;
   logic [15:0] sw_val;
   logic [15:0] nxt_flags;

   always_comb begin
      sw_mask = {{8{byte_wr[1]}}, {8{byte_wr[0]}}} | bit_wr;
      sw_val  = (|byte_wr) ? wr_data : {16{bit_val}};
      nxt_flags = (flags_ff & ~sw_mask) | (sw_val & sw_mask);
      nxt_flags = nxt_flags & ~ack_clr;
      // Hardware set applied last so it beats any clear
      nxt_flags = nxt_flags | hw_set;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flags_ff <= `IRQFB_RST_FLAG;
      end else begin
         flags_ff <= nxt_flags;
      end
   end
endmodule // irqfb_flag_group

// >>> irqfb_map.svh
// Offsets, field positions, reset values and timing counts of the request flag bank
`ifndef IRQFB_MAP_SVH
`define IRQFB_MAP_SVH

`define IRQFB_NGRP        3
`define IRQFB_NSRC        48

// Byte address = {page, word, 2'b00}
`define IRQFB_PG_FLAG     4'h0
`define IRQFB_PG_MASK     4'h1
`define IRQFB_PG_PRIO0    4'h2
`define IRQFB_PG_PRIO1    4'h3
`define IRQFB_PG_CTRL     4'h4
`define IRQFB_WD_BITOP    2'h3
`define IRQFB_WD_EVT_STAT 2'h0
`define IRQFB_WD_EVT_MASK 2'h1
`define IRQFB_WD_CORE     2'h2

`define IRQFB_BITOP_VAL   8
`define IRQFB_BIT_SH_TX   6'd13
`define IRQFB_BIT_SH_RX   6'd14

`define IRQFB_RST_FLAG    16'h0000
`define IRQFB_RST_MASK    16'hffff
`define IRQFB_RST_PRIO    16'hffff
`define IRQFB_RST_EVT     3'h0

`define IRQFB_EVT_ACK     0
`define IRQFB_EVT_OVR     1
`define IRQFB_EVT_SWR     2

`define IRQFB_FLAG_WR_EXTRA 2'd2

`endif

// >>> irqfb_pkg.sv
// Types shared by the request flag bank
package irqfb_pkg;
   typedef enum logic [2:0] {
      IRQFB_IDLE = 3'b001,
      IRQFB_WAIT = 3'b010,
      IRQFB_ACK  = 3'b100
   } irqfb_bus_state_e;
   typedef logic [5:0] irqfb_src_t;
endpackage

// >>> irqfb_top.sv
// Interrupt request flag bank: flags, masks, priorities, core hand-off, bus slave
`timescale 1ns/10ps
`include "irqfb_map.svh"
// Behaviour
// - Source request or software one sets flag
// - Core acknowledge clears that flag automatically
// - Reset clears all six flag bytes
// - Byte, bit and 16-bit flag writes
// - Flag writes answer two clocks later
// - Bit 13 set by tx-end or serial-a
// - Bit 14 set by rx-end or serial-b
// - Each source: flag, mask, two priority bits
// - Group zero holds the listed sources
// - Priority 00 highest, 11 lowest
// - Pending held until enabled plus one instruction
// - Low byte: watchdog, low-voltage, pins 0-5
module irqfb_top (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic      [31:0] wb_dat_r,
   output logic             wb_ack,
   input  wire logic [47:0] src_req,
   input  wire logic        serial0_tx_end_request,
   input  wire logic        clocked_serial_a_request,
   input  wire logic        serial0_rx_end_request,
   input  wire logic        clocked_serial_b_request,
   input  wire logic        core_ie,
   input  wire logic        core_instr_done,
   input  wire logic        core_ack,
   output logic             int_req,
   output logic      [5:0]  int_src,
   output logic      [1:0]  int_level,
   output logic             irq
);
   // ****************************************
   // Declarations
   // ****************************************
   irqfb_pkg::irqfb_bus_state_e st_ff;
   irqfb_pkg::irqfb_bus_state_e nxt_st;
   logic [1:0]  wait_cnt_ff;
   logic [47:0] hw_set;
   logic [47:0] flags_all;
   logic [47:0] ack_clr;
   logic [47:0] bit_wr;
   logic [15:0] mask_ff  [0:2];
   logic [15:0] prio0_ff [0:2];
   logic [15:0] prio1_ff [0:2];
   logic [47:0] mask_all;
   logic [47:0] prio0_all;
   logic [47:0] prio1_all;
   logic [2:0]  evt_stat_ff;
   logic [2:0]  evt_mask_ff;
   logic [2:0]  evt_set;
   logic [31:0] rd_val;
   logic [31:0] rdat_ff;
   logic        req_go;
   logic        wr_now;
   logic        flag_page;
   logic        flag_wr_req;
   logic        bitop_now;
   logic [1:0]  grp;
   logic        found;
   logic [5:0]  best_src;
   logic [1:0]  best_lvl;
   logic        found_ff;
   logic [5:0]  src_ff;
   logic [1:0]  lvl_ff;
   logic        gate_ff;
   logic        ack_hold_ff;

   // ****************************************
   // Request sources
   // ****************************************
   always_comb begin
      hw_set = src_req;
      // Shared positions cannot tell their two sources apart
      hw_set[`IRQFB_BIT_SH_TX] = src_req[`IRQFB_BIT_SH_TX] | serial0_tx_end_request
                                 | clocked_serial_a_request;
      hw_set[`IRQFB_BIT_SH_RX] = src_req[`IRQFB_BIT_SH_RX] | serial0_rx_end_request
                                 | clocked_serial_b_request;
   end

   // ****************************************
   // Bus decode and timing
   // ****************************************
   assign req_go      = wb_cyc && wb_stb && (st_ff == irqfb_pkg::IRQFB_IDLE);
   assign grp         = wb_adr[3:2];
   assign flag_page   = (wb_adr[7:4] == `IRQFB_PG_FLAG);
   assign flag_wr_req = wb_we && flag_page;
   assign wr_now      = wb_cyc && wb_stb && wb_we && (st_ff == irqfb_pkg::IRQFB_ACK);
   assign bitop_now   = wr_now && flag_page && (grp == `IRQFB_WD_BITOP);
   assign wb_ack      = (st_ff == irqfb_pkg::IRQFB_ACK);
   assign wb_dat_r    = rdat_ff;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         irqfb_pkg::IRQFB_IDLE: begin
            if (req_go && flag_wr_req) begin
               nxt_st = irqfb_pkg::IRQFB_WAIT;
            end else if (req_go) begin
               nxt_st = irqfb_pkg::IRQFB_ACK;
            end
         end
         irqfb_pkg::IRQFB_WAIT: begin
            if (wait_cnt_ff == 2'd0) begin
               nxt_st = irqfb_pkg::IRQFB_ACK;
            end
         end
         irqfb_pkg::IRQFB_ACK: begin
            nxt_st = irqfb_pkg::IRQFB_IDLE;
         end
         default: begin
            nxt_st = irqfb_pkg::IRQFB_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ff       <= irqfb_pkg::IRQFB_IDLE;
         wait_cnt_ff <= 2'd0;
      end else begin
         st_ff <= nxt_st;
         if (req_go && flag_wr_req) begin
            wait_cnt_ff <= `IRQFB_FLAG_WR_EXTRA - 2'd1;
         end else if (wait_cnt_ff != 2'd0) begin
            wait_cnt_ff <= wait_cnt_ff - 2'd1;
         end
      end
   end

   // ****************************************
   // Flag groups
   // ****************************************
   always_comb begin
      bit_wr = 48'h0;
      if (bitop_now) begin
         bit_wr[wb_dat_w[5:0]] = (wb_dat_w[5:4] != 2'd3);
      end
   end

   // Flags of the presented source drop as the core takes it
   assign ack_clr = core_ack ? (48'h1 << src_ff) : 48'h0;

   genvar g;
   generate
      for (g = 0; g < `IRQFB_NGRP; g = g + 1) begin : gen_grp
         logic [1:0] bw;
         assign bw = (wr_now && flag_page && (grp == 2'(g))) ? wb_sel[1:0] : 2'b00;
         irqfb_flag_group u_grp (
            .core_clk (core_clk),
            .rst      (rst),
            .hw_set   (hw_set[16*g+15:16*g]),
            .byte_wr  (bw),
            .wr_data  (wb_dat_w[15:0]),
            .bit_wr   (bit_wr[16*g+15:16*g]),
            .bit_val  (wb_dat_w[`IRQFB_BITOP_VAL]),
            .ack_clr  (ack_clr[16*g+15:16*g]),
            .flags_ff (flags_all[16*g+15:16*g])
         );
         assign mask_all[16*g+15:16*g]  = mask_ff[g];
         assign prio0_all[16*g+15:16*g] = prio0_ff[g];
         assign prio1_all[16*g+15:16*g] = prio1_ff[g];
      end
   endgenerate

   // ****************************************
   // Mask and priority registers
   // ****************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `IRQFB_NGRP; i++) begin
            mask_ff[i]  <= `IRQFB_RST_MASK;
            prio0_ff[i] <= `IRQFB_RST_PRIO;
            prio1_ff[i] <= `IRQFB_RST_PRIO;
         end
      end else if (wr_now && (grp != 2'd3)) begin
         for (int b = 0; b < 2; b++) begin
            if (wb_sel[b]) begin
               if (wb_adr[7:4] == `IRQFB_PG_MASK) begin
                  mask_ff[grp][8*b +: 8] <= wb_dat_w[8*b +: 8];
               end else if (wb_adr[7:4] == `IRQFB_PG_PRIO0) begin
                  prio0_ff[grp][8*b +: 8] <= wb_dat_w[8*b +: 8];
               end else if (wb_adr[7:4] == `IRQFB_PG_PRIO1) begin
                  prio1_ff[grp][8*b +: 8] <= wb_dat_w[8*b +: 8];
               end
            end
         end
      end
   end

   // ****************************************
   // Priority resolution
   // ****************************************
   // Lowest level wins, then lowest index; masked flags stay pending
   always_comb begin
      found    = 1'b0;
      best_src = 6'h00;
      best_lvl = 2'h3;
      for (int s = 0; s < `IRQFB_NSRC; s++) begin
         if (flags_all[s] && !mask_all[s]) begin
            if (!found || ({prio1_all[s], prio0_all[s]} < best_lvl)) begin
               found    = 1'b1;
               best_src = s[5:0];
               best_lvl = {prio1_all[s], prio0_all[s]};
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         found_ff <= 1'b0;
         src_ff   <= 6'h00;
         lvl_ff   <= 2'h3;
      end else begin
         found_ff <= found;
         src_ff   <= best_src;
         lvl_ff   <= best_lvl;
      end
   end

   // ****************************************
   // Core hand-off
   // ****************************************
   // Enable rising is not enough: one more main instruction must retire
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gate_ff <= 1'b0;
      end else if (!core_ie) begin
         gate_ff <= 1'b0;
      end else if (core_instr_done) begin
         gate_ff <= 1'b1;
      end
   end

   // Stale winner is hidden for one cycle after an acknowledge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_hold_ff <= 1'b0;
      end else begin
         ack_hold_ff <= core_ack;
      end
   end

   assign int_req   = gate_ff && found_ff && !ack_hold_ff;
   assign int_src   = src_ff;
   assign int_level = lvl_ff;

   // ****************************************
   // Event status and interrupt line
   // ****************************************
   always_comb begin
      evt_set = 3'h0;
      evt_set[`IRQFB_EVT_ACK] = core_ack;
      evt_set[`IRQFB_EVT_OVR] = |(hw_set & flags_all);
      evt_set[`IRQFB_EVT_SWR] = wr_now && flag_page;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         evt_stat_ff <= `IRQFB_RST_EVT;
         evt_mask_ff <= `IRQFB_RST_EVT;
      end else begin
         if (wr_now && wb_sel[0] && (wb_adr[7:4] == `IRQFB_PG_CTRL) && (grp == `IRQFB_WD_EVT_STAT)) begin
            evt_stat_ff <= (evt_stat_ff & ~wb_dat_w[2:0]) | evt_set;
         end else begin
            evt_stat_ff <= evt_stat_ff | evt_set;
         end
         if (wr_now && wb_sel[0] && (wb_adr[7:4] == `IRQFB_PG_CTRL) && (grp == `IRQFB_WD_EVT_MASK)) begin
            evt_mask_ff <= wb_dat_w[2:0];
         end
      end
   end

   assign irq = |(evt_stat_ff & evt_mask_ff);

   // ****************************************
   // Read path
   // ****************************************
   always_comb begin
      rd_val = 32'h0;
      if (flag_page && (grp != `IRQFB_WD_BITOP)) begin
         rd_val[15:0] = flags_all[16*grp +: 16];
      end else if ((wb_adr[7:4] == `IRQFB_PG_MASK) && (grp != 2'd3)) begin
         rd_val[15:0] = mask_ff[grp];
      end else if ((wb_adr[7:4] == `IRQFB_PG_PRIO0) && (grp != 2'd3)) begin
         rd_val[15:0] = prio0_ff[grp];
      end else if ((wb_adr[7:4] == `IRQFB_PG_PRIO1) && (grp != 2'd3)) begin
         rd_val[15:0] = prio1_ff[grp];
      end else if ((wb_adr[7:4] == `IRQFB_PG_CTRL) && (grp == `IRQFB_WD_EVT_STAT)) begin
         rd_val[2:0] = evt_stat_ff;
      end else if ((wb_adr[7:4] == `IRQFB_PG_CTRL) && (grp == `IRQFB_WD_EVT_MASK)) begin
         rd_val[2:0] = evt_mask_ff;
      end else if ((wb_adr[7:4] == `IRQFB_PG_CTRL) && (grp == `IRQFB_WD_CORE)) begin
         rd_val[9:0] = {gate_ff, found_ff, lvl_ff, src_ff};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdat_ff <= 32'h0;
      end else if (nxt_st == irqfb_pkg::IRQFB_ACK) begin
         rdat_ff <= rd_val;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_HW_SET: assert property ((hw_set != 48'h0) |=> ((flags_all & $past(hw_set)) == $past(hw_set)))
      else $error("request flag not set by source");
   AST_ACK_CLEAR: assert property ((core_ack && !hw_set[src_ff] && !wr_now) |=> !flags_all[$past(src_ff)])
      else $error("acknowledged flag not cleared");
   AST_RESET_ZERO: assert property (disable iff (1'b0) rst |=> (flags_all == 48'h0))
      else $error("flags not zero after reset");
   AST_FLAG_WR_DELAY: assert property ((req_go && flag_wr_req) |=> !wb_ack ##1 !wb_ack ##1 wb_ack)
      else $error("flag write not answered at third cycle");
   AST_PLAIN_DELAY: assert property ((req_go && !flag_wr_req) |=> wb_ack)
      else $error("plain access not answered next cycle");
   AST_SHARED_TX: assert property ((serial0_tx_end_request || clocked_serial_a_request)
      |=> flags_all[`IRQFB_BIT_SH_TX])
      else $error("shared bit 13 not set");
   AST_SHARED_RX: assert property ((serial0_rx_end_request || clocked_serial_b_request)
      |=> flags_all[`IRQFB_BIT_SH_RX])
      else $error("shared bit 14 not set");
   // Winner and level were resolved one cycle earlier, so compare with the settings of then
   AST_LEVEL_MATCH: assert property (int_req
      |-> (int_level == {$past(prio1_all[best_src]), $past(prio0_all[best_src])}))
      else $error("level does not match source priority");
   AST_MASK_BLOCKS: assert property (int_req |-> !$past(mask_all[best_src]))
      else $error("masked source presented");
   AST_HOLD_PENDING: assert property ($rose(core_ie) |-> !int_req ##1 !int_req)
      else $error("request presented without a further instruction");
   AST_BIT_CLEAR: assert property ((bitop_now && !wb_dat_w[`IRQFB_BITOP_VAL] && (wb_dat_w[5:4] != 2'd3)
      && !hw_set[wb_dat_w[5:0]]) |=> !flags_all[$past(wb_dat_w[5:0])])
      else $error("bit write of zero did not clear flag");

   COV_FLAG_WR: cover property (req_go && flag_wr_req ##3 wb_ack);
   COV_CORE_ACK: cover property (int_req ##1 core_ack);
   COV_SHARED: cover property (serial0_tx_end_request && clocked_serial_a_request);
   COV_MASKED: cover property (found_ff == 1'b0 && flags_all != 48'h0);
endmodule // irqfb_top

// >>> tb_irqfb_top.sv
// Self-checking testbench of the request flag bank
`timescale 1ns/10ps
`include "irqfb_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_irqfb_top;
   // ********************************************
   // Signals and instances
   // ********************************************
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        wb_cyc   = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
   logic [7:0]  wb_adr   = 8'h00;
   logic [3:0]  wb_sel   = 4'h0;
   logic [31:0] wb_dat_w = 32'h0, wb_dat_r, rdat;
   logic [47:0] src_req  = 48'h0;
   logic [3:0]  ser      = 4'h0;
   logic        ie_en    = 1'b0, ack_en = 1'b0, core_ie, core_instr_done, core_ack, int_req, irq;
   logic [3:0]  ack_dly  = 4'h0;
   logic [5:0]  int_src, last_src;
   logic [1:0]  int_level, last_lvl;
   logic [7:0]  ack_cnt;
   int          err_count = 0, num_checks = 0, lat, nm, i;
   int          idx [7] = '{0, 1, 2, 7, 15, 16, 47};
   always #5 core_clk = ~core_clk;
   irqfb_top dut_u (.core_clk(core_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
      .src_req(src_req), .serial0_tx_end_request(ser[3]), .clocked_serial_a_request(ser[2]),
      .serial0_rx_end_request(ser[1]), .clocked_serial_b_request(ser[0]), .core_ie(core_ie),
      .core_instr_done(core_instr_done), .core_ack(core_ack), .int_req(int_req), .int_src(int_src),
      .int_level(int_level), .irq(irq));
   irqfb_core_model core_u (.core_clk(core_clk), .rst(rst), .ie_en(ie_en), .ack_en(ack_en),
      .ack_dly(ack_dly), .int_req(int_req), .int_src(int_src), .int_level(int_level), .core_ie(core_ie),
      .core_instr_done(core_instr_done), .core_ack(core_ack), .last_src(last_src), .last_lvl(last_lvl),
      .ack_cnt(ack_cnt));
   // ********************************************
   // Tasks
   // ********************************************
   task automatic end_sim;
      if (err_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Master makes no guess at latency: it polls ack under a bound
   task automatic wb(input logic we, input logic [7:0] a, input logic [1:0] s, input logic [15:0] d);
      int n;
      n = 0;
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= a;
      wb_sel   <= {2'b00, s};
      wb_dat_w <= {16'h0000, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) begin
         err_count++;
         end_sim();
      end
      rdat   = wb_dat_r;
      lat    = n;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 2'b11, 16'h0000);
      `CHK(rdat, e)
   endtask
   task automatic wr(input logic [7:0] a, input logic [1:0] s, input logic [15:0] d);
      wb(1'b1, a, s, d);
   endtask
   task automatic hw(input logic [47:0] v);
      src_req <= v;
      @(posedge core_clk);
      src_req <= 48'h0;
      @(posedge core_clk);
   endtask
   task automatic wait_acks(input logic [7:0] k);
      for (int t = 0; t < 300 && ack_cnt < k; t++) @(posedge core_clk);
      if (ack_cnt < k) begin
         err_count++;
         end_sim();
      end
   endtask
   // ********************************************
   // Sequence
   // ********************************************
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      `CHK(int_req, 1'b0)
      `CHK(irq, 1'b0)
      for (i = 0; i < 3; i++) begin
         rd(8'(4 * i), 32'h0);
         rd(8'(8'h10 + 4 * i), {16'h0, `IRQFB_RST_MASK});
         rd(8'(8'h20 + 4 * i), {16'h0, `IRQFB_RST_PRIO});
         rd(8'(8'h30 + 4 * i), {16'h0, `IRQFB_RST_PRIO});
      end
      rd(8'h50, 32'h0);
      rd(8'h40, 32'h0);
      rd(8'h48, 32'h00c0);
      wr(8'h10, 2'b11, 16'hffff);
      nm = lat;
      wr(8'h00, 2'b01, 16'h00a5);
      `CHK(lat - nm, `IRQFB_FLAG_WR_EXTRA)
      rd(8'h00, 32'h00a5);
      wr(8'h00, 2'b10, 16'h5a00);
      rd(8'h00, 32'h5aa5);
      wr(8'h00, 2'b11, 16'h5aa4);
      rd(8'h00, 32'h5aa4);
      wr(8'h0c, 2'b11, 16'h0114);
      rd(8'h04, 32'h0010);
      wr(8'h0c, 2'b11, 16'h0014);
      wr(8'h0c, 2'b11, 16'h0130);
      rd(8'h04, 32'h0000);
      rd(8'h00, 32'h5aa4);
      wr(8'h00, 2'b11, 16'h0000);
      // Hardware sets land at their documented positions
      for (i = 0; i < 7; i++) begin
         hw(48'h1 << idx[i]);
         rd(8'(4 * (idx[i] / 16)), 32'h1 << (idx[i] % 16));
         wr(8'(4 * (idx[i] / 16)), 2'b11, 16'h0000);
      end
      // One sharing unit at a time, never two together
      for (i = 0; i < 4; i++) begin
         ser <= 4'b1000 >> i;
         @(posedge core_clk);
         ser <= 4'h0;
         @(posedge core_clk);
         rd(8'h00, (i < 2) ? 32'h2000 : 32'h4000);
         wr(8'h00, 2'b11, 16'h0000);
      end
      // Bit 5 at level 0 must beat bit 2 at level 3 despite the higher index
      wr(8'h10, 2'b11, 16'hffdb);
      wr(8'h20, 2'b11, 16'hffdf);
      wr(8'h30, 2'b11, 16'hffdf);
      wr(8'h44, 2'b11, 16'h0001);
      wr(8'h00, 2'b11, 16'h0024);
      hw(48'h1 << 16);
      repeat (6) @(posedge core_clk);
      `CHK(int_req, 1'b0)
      rd(8'h00, 32'h0024);
      rd(8'h48, 32'h0105);
      ie_en  <= 1'b1;
      ack_en <= 1'b1;
      wait_acks(8'h01);
      `CHK(last_src, 6'd5)
      `CHK(last_lvl, 2'b00)
      ack_dly <= 4'h4;
      wait_acks(8'h02);
      `CHK(last_src, 6'd2)
      `CHK(last_lvl, 2'b11)
      rd(8'h00, 32'h0000);
      rd(8'h04, 32'h0001);
      `CHK(int_req, 1'b0)
      `CHK(irq, 1'b1)
      wr(8'h40, 2'b11, 16'h0007);
      `CHK(irq, 1'b0)
      wr(8'h44, 2'b11, 16'h0004);
      wr(8'h00, 2'b01, 16'h0000);
      `CHK(irq, 1'b1)
      wr(8'h40, 2'b11, 16'h0004);
      `CHK(irq, 1'b0)
      // A request on a flag that is still pending counts as an overrun
      wr(8'h44, 2'b11, 16'h0002);
      hw(48'h1 << 16);
      `CHK(irq, 1'b1)
      wr(8'h40, 2'b11, 16'h0002);
      `CHK(irq, 1'b0)
      rd(8'h04, 32'h0001);
      end_sim();
   end
endmodule // tb_irqfb_top
